// ### rtl/core_event_select_decoder.sv
// Purpose: Selects one core event by number and unit mask and counts it.
// Assumes: Event sources are synchronous to core_clk; no synchronisers.
// Notes:   A software write to the count register wins over an increment.
`timescale 1ns/1ps

// Function
// R1: 10H counts scalar/packed single, scalar double uops.
// R2: 11H counts 256-bit packed single or double.
// R3: 14H counts divider busy cycles or divides.
// R4: 17H adds instruction queue writes per cycle.
// R5: 24H demand read hits, or all demand reads.
// R6: 24H store ownership hits, misses, or all.
// R7: 24H code fetch hits, misses, or all.
// R8: 24H prefetcher hits, misses, or both.
// R9: 27H store lock misses, E hits, M hits, all.
// R10: 28H accepted writebacks to E or M lines.
// R11: 2EH last level references or misses.
// R12: 3CH/00H counts core cycles while not halted.
// R13: 3CH/01H counts reference rate while not halted.
// R14: 48H adds pending misses, counter 2 only.
// R15: 49H counts store walks of any page size.
// R16: Threshold turns counts into cycles; edge rises.
// R17: Eight-bit fields; unlisted selections count nothing.
module core_event_select_decoder #(
    parameter int COUNT_W = 32
) (
    // Clock and reset.
    input  wire logic                                core_clk,
    input  wire logic                                sys_rst,
    // Register port.
    input  wire core_event_pkg::reg_req_s            busReq,
    output logic [core_event_pkg::DATA_W-1:0]        rdData,
    // Event sources.
    input  wire core_event_pkg::event_src_s          events,
    // Running count.
    output logic [COUNT_W-1:0]                       eventCount
);

    localparam int SUM_W = core_event_pkg::SUM_W;

    core_event_pkg::sel_cfg_s   sel_reg;
    logic [COUNT_W-1:0]         count_reg;
    logic [COUNT_W-1:0]         count_next;
    logic                       condPrev_reg;
    logic [5:0]                 refPhase_reg;
    logic [7:0]                 refSum;
    logic [1:0]                 refInc;
    logic [SUM_W-1:0]           eventValue;
    logic                       selLegal;
    logic [SUM_W-1:0]           addAmount;
    logic [7:0]                 effThr;
    logic                       cond;
    logic                       plainMode;
    logic                       selWrite;
    logic                       cntWrite;
    logic [core_event_pkg::DATA_W-1:0] rdMux;
    logic [7:0][core_event_pkg::SRC_W-1:0] fpVec;
    logic [7:0][core_event_pkg::SRC_W-1:0] l2Vec;
    logic [7:0][core_event_pkg::SRC_W-1:0] lockVec;
    logic [7:0]                 um;

    // Adds every source whose unit-mask bit is set.
    function automatic logic [SUM_W-1:0] maskedSum(
        input logic [7:0][core_event_pkg::SRC_W-1:0] v,
        input logic [7:0]                            m
    );
        logic [SUM_W-1:0] s;
        s = '0;
        for (int i = 0; i < 8; i++) begin
            if (m[i]) begin
                s = s + SUM_W'(v[i]);
            end
        end
        return s;
    endfunction

    // Bus decode.
    assign selWrite = busReq.wrEn && busReq.addr == core_event_pkg::REG_SELECT;
    assign cntWrite = busReq.wrEn && busReq.addr == core_event_pkg::REG_COUNT;
    assign um       = sel_reg.unitMask;

    // Unit-mask bit positions mapped onto their sources.
    assign fpVec = {events.fpScalarDouble, events.fpPackedSingle,
                    events.fpScalarSingle, 20'h0};
    assign l2Vec = {events.l2PfMiss, events.l2PfHit, events.l2CodeMiss,
                    events.l2CodeHit, events.l2RfoMiss, events.l2RfoHit,
                    events.l2DemandOther, events.l2DemandHit};
    assign lockVec = {16'h0, events.lockHitM, events.lockHitE,
                      events.lockHitS, events.lockMiss};

    // The reference rate advances by a fractional step each core cycle.
    assign refSum = 8'(refPhase_reg) + 8'(core_event_pkg::REF_CLK_MHZ);
    assign refInc = 2'(refSum / 8'(core_event_pkg::CORE_CLK_MHZ));

    // Event selection: value of the chosen event and legality of the pair.
    always_comb begin
        eventValue = '0;
        selLegal   = 1'b0;
        unique case (sel_reg.eventNum)
            core_event_pkg::EV_FP_UOPS_EXECUTED: begin
                selLegal = um == core_event_pkg::UM_SCALAR_SINGLE ||
                           um == core_event_pkg::UM_PACKED_SINGLE ||
                           um == core_event_pkg::UM_SCALAR_DOUBLE; // [R1]
                eventValue = maskedSum(fpVec, um);
            end
            core_event_pkg::EV_WIDE_SIMD_FP: begin
                selLegal = um == core_event_pkg::UM_WIDE_SINGLE ||
                           um == core_event_pkg::UM_WIDE_DOUBLE; // [R2]
                eventValue = (um == core_event_pkg::UM_WIDE_SINGLE) ?
                    SUM_W'(events.wideSingle) : SUM_W'(events.wideDouble);
            end
            core_event_pkg::EV_DIVIDER_BUSY: begin
                selLegal   = um == core_event_pkg::UM_ONLY; // [R3]
                eventValue = SUM_W'(events.dividerBusy);
            end
            core_event_pkg::EV_QUEUE_WRITE_COUNT: begin
                selLegal   = um == core_event_pkg::UM_ONLY; // [R4]
                eventValue = SUM_W'(events.queueWrites);
            end
            core_event_pkg::EV_SECOND_LEVEL_REQ: begin
                selLegal = um == core_event_pkg::UM_DEMAND_HIT ||
                           um == core_event_pkg::UM_DEMAND_ALL || // [R5]
                           um == core_event_pkg::UM_RFO_HIT ||
                           um == core_event_pkg::UM_RFO_MISS ||
                           um == core_event_pkg::UM_RFO_ALL || // [R6]
                           um == core_event_pkg::UM_CODE_HIT ||
                           um == core_event_pkg::UM_CODE_MISS ||
                           um == core_event_pkg::UM_CODE_ALL || // [R7]
                           um == core_event_pkg::UM_PF_HIT ||
                           um == core_event_pkg::UM_PF_MISS ||
                           um == core_event_pkg::UM_PF_ALL; // [R8]
                eventValue = maskedSum(l2Vec, um);
            end
            core_event_pkg::EV_STORE_LOCK_REQ: begin
                selLegal = um == core_event_pkg::UM_LOCK_MISS ||
                           um == core_event_pkg::UM_LOCK_HIT_E ||
                           um == core_event_pkg::UM_LOCK_HIT_M ||
                           um == core_event_pkg::UM_LOCK_ALL; // [R9]
                eventValue = maskedSum(lockVec, um);
            end
            core_event_pkg::EV_FIRST_LEVEL_WB: begin
                selLegal = um == core_event_pkg::UM_WB_HIT_E ||
                           um == core_event_pkg::UM_WB_HIT_M; // [R10]
                eventValue = (um == core_event_pkg::UM_WB_HIT_E) ?
                    SUM_W'(events.wbHitE) : SUM_W'(events.wbHitM);
            end
            core_event_pkg::EV_LAST_LEVEL_ACCESS: begin
                selLegal = um == core_event_pkg::UM_LLC_REFERENCE ||
                           um == core_event_pkg::UM_LLC_MISS; // [R11]
                eventValue = (um == core_event_pkg::UM_LLC_MISS) ?
                    SUM_W'(events.llcMiss) : SUM_W'(events.llcReference);
            end
            core_event_pkg::EV_UNHALTED: begin
                selLegal = um == core_event_pkg::UM_CORE_CYCLES ||
                           um == core_event_pkg::UM_REF_CYCLES;
                if (events.threadHalted) begin
                    eventValue = '0; // [R12] [R13]
                end else if (um == core_event_pkg::UM_REF_CYCLES) begin
                    eventValue = SUM_W'(refInc); // [R13]
                end else begin
                    eventValue = SUM_W'(1'b1); // [R12]
                end
            end
            core_event_pkg::EV_PENDING_DATA_MISS: begin
                selLegal = um == core_event_pkg::UM_ONLY &&
                           sel_reg.slot ==
                           core_event_pkg::PENDING_SLOT; // [R14]
                eventValue = SUM_W'(events.pendingMisses);
            end
            core_event_pkg::EV_STORE_XLATE_MISS: begin
                selLegal   = um == core_event_pkg::UM_ONLY; // [R15]
                eventValue = SUM_W'(events.storeWalks);
            end
            default: begin
                selLegal   = 1'b0; // [R17]
                eventValue = '0;
            end
        endcase
    end

    // Threshold and edge shaping of the per-cycle value.
    assign plainMode = sel_reg.threshold == '0 && !sel_reg.edgeDetect;
    assign effThr    = (sel_reg.threshold == '0) ? 8'h01 : sel_reg.threshold;
    assign cond      = selLegal && {1'b0, eventValue} >= effThr; // [R16]
    assign addAmount = !selLegal ? '0 : // [R17]
                       plainMode ? eventValue :
                       sel_reg.edgeDetect ? SUM_W'(cond && !condPrev_reg) :
                       SUM_W'(cond); // [R16] [R3] [R14]
    assign count_next = cntWrite ? COUNT_W'(busReq.wrData) :
                        count_reg + COUNT_W'(addAmount);

    // Read data selection; unmapped offsets read zero.
    assign rdMux = (busReq.addr == core_event_pkg::REG_SELECT) ? sel_reg :
                   (busReq.addr == core_event_pkg::REG_COUNT) ?
                       32'(count_reg) :
                   (busReq.addr == core_event_pkg::REG_STATUS) ?
                       {30'h0, condPrev_reg, selLegal} : 32'h0;

    // Selection register.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sel_reg <= core_event_pkg::SELECT_RST;
        end else if (selWrite) begin
            sel_reg <= busReq.wrData; // [R17]
        end
    end

    // Counter, condition history and reference phase.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count_reg    <= '0;
            condPrev_reg <= 1'b0;
            refPhase_reg <= '0;
        end else begin
            count_reg    <= count_next;
            condPrev_reg <= cond && !selWrite;
            refPhase_reg <= 6'(refSum % 8'(core_event_pkg::CORE_CLK_MHZ));
        end
    end

    // Read data register, valid the cycle after the strobe.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdData <= '0;
        end else begin
            rdData <= busReq.rdEn ? rdMux : '0;
        end
    end

    assign eventCount = count_reg;

    // Checks on the counting behaviour.
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    logic quiet;
    assign quiet = !cntWrite;

    sequence refRunning;
        (sel_reg.eventNum == core_event_pkg::EV_UNHALTED &&
         um == core_event_pkg::UM_REF_CYCLES && plainMode &&
         !events.threadHalted && quiet && !selWrite) [*2];
    endsequence

    a_unlisted_hold: assert property ( // [R17]
        !selLegal && quiet |=> count_reg == $past(count_reg))
        else $error("Unlisted selection changed the count.");

    a_plain_add: assert property ( // [R16]
        selLegal && plainMode && quiet |=>
        count_reg == $past(count_reg) + COUNT_W'($past(eventValue)))
        else $error("Plain mode did not add the event value.");

    a_thresh_cycle: assert property ( // [R16]
        selLegal && sel_reg.threshold != '0 && !sel_reg.edgeDetect &&
        quiet |=> count_reg - $past(count_reg) ==
        COUNT_W'({1'b0, $past(eventValue)} >= $past(sel_reg.threshold)))
        else $error("Threshold mode added a wrong amount.");

    a_fp_scalar: assert property ( // [R1]
        sel_reg.eventNum == core_event_pkg::EV_FP_UOPS_EXECUTED &&
        um == core_event_pkg::UM_SCALAR_SINGLE && plainMode && quiet |=>
        count_reg == $past(count_reg) +
        COUNT_W'($past(events.fpScalarSingle)))
        else $error("Scalar single uops miscounted.");

    a_div_edge: assert property ( // [R3]
        sel_reg.eventNum == core_event_pkg::EV_DIVIDER_BUSY &&
        um == core_event_pkg::UM_ONLY && sel_reg.edgeDetect &&
        sel_reg.threshold == 8'h01 && quiet && !selWrite &&
        events.dividerBusy ##1 events.dividerBusy && quiet |=>
        count_reg == $past(count_reg))
        else $error("Busy divider counted twice in edge mode.");

    a_l2_pf_all: assert property ( // [R8]
        sel_reg.eventNum == core_event_pkg::EV_SECOND_LEVEL_REQ &&
        um == core_event_pkg::UM_PF_ALL && plainMode && quiet |=>
        count_reg == $past(count_reg) + COUNT_W'($past(events.l2PfHit)) +
        COUNT_W'($past(events.l2PfMiss)))
        else $error("Prefetcher total miscounted.");

    a_halt_gate: assert property ( // [R12]
        sel_reg.eventNum == core_event_pkg::EV_UNHALTED &&
        events.threadHalted && quiet |=> count_reg == $past(count_reg))
        else $error("Halted thread advanced the cycle count.");

    a_ref_rate: assert property ( // [R13]
        refRunning |=> count_reg == $past(count_reg, 2) + COUNT_W'(5))
        else $error("Reference rate off over two core cycles.");

    a_pend_slot: assert property ( // [R14]
        sel_reg.eventNum == core_event_pkg::EV_PENDING_DATA_MISS &&
        sel_reg.slot != core_event_pkg::PENDING_SLOT && quiet |=>
        $stable(count_reg))
        else $error("Pending misses counted outside slot two.");

    a_store_walk: assert property ( // [R15]
        sel_reg.eventNum == core_event_pkg::EV_STORE_XLATE_MISS &&
        um == core_event_pkg::UM_ONLY && plainMode && quiet |=>
        count_reg == $past(count_reg) + COUNT_W'($past(events.storeWalks)))
        else $error("Store walks miscounted.");

    a_count_load: assert property (
        cntWrite |=> count_reg == COUNT_W'($past(busReq.wrData)))
        else $error("Count register write not taken.");

endmodule

// ### rtl/core_event_pkg.sv
// Purpose: Shared constants and carriers for the event-select decoder.
// Assumes: A 40 MHz core clock and a fixed 100 MHz reference rate.
// Notes:   Register offsets are byte addresses on a 32-bit data path.
package core_event_pkg;

    // Widths of the selection fields, of each per-cycle event count and their sum, and of the register port.
    localparam int EVT_W  = 8;
    localparam int MASK_W = 8;
    localparam int THR_W  = 8;
    localparam int SRC_W  = 4;
    localparam int SUM_W  = 7;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 4;

    // Event numbers.
    localparam logic [7:0] EV_FP_UOPS_EXECUTED   = 8'h10;
    localparam logic [7:0] EV_WIDE_SIMD_FP       = 8'h11;
    localparam logic [7:0] EV_DIVIDER_BUSY       = 8'h14;
    localparam logic [7:0] EV_QUEUE_WRITE_COUNT  = 8'h17;
    localparam logic [7:0] EV_SECOND_LEVEL_REQ   = 8'h24;
    localparam logic [7:0] EV_STORE_LOCK_REQ     = 8'h27;
    localparam logic [7:0] EV_FIRST_LEVEL_WB     = 8'h28;
    localparam logic [7:0] EV_LAST_LEVEL_ACCESS  = 8'h2e;
    localparam logic [7:0] EV_UNHALTED           = 8'h3c;
    localparam logic [7:0] EV_PENDING_DATA_MISS  = 8'h48;
    localparam logic [7:0] EV_STORE_XLATE_MISS   = 8'h49;

    // Unit masks.
    localparam logic [7:0] UM_SCALAR_SINGLE = 8'h20;
    localparam logic [7:0] UM_PACKED_SINGLE = 8'h40;
    localparam logic [7:0] UM_SCALAR_DOUBLE = 8'h80;
    localparam logic [7:0] UM_WIDE_SINGLE   = 8'h01;
    localparam logic [7:0] UM_WIDE_DOUBLE   = 8'h02;
    localparam logic [7:0] UM_ONLY          = 8'h01;
    localparam logic [7:0] UM_DEMAND_HIT    = 8'h01;
    localparam logic [7:0] UM_DEMAND_ALL    = 8'h03;
    localparam logic [7:0] UM_RFO_HIT       = 8'h04;
    localparam logic [7:0] UM_RFO_MISS      = 8'h08;
    localparam logic [7:0] UM_RFO_ALL       = 8'h0c;
    localparam logic [7:0] UM_CODE_HIT      = 8'h10;
    localparam logic [7:0] UM_CODE_MISS     = 8'h20;
    localparam logic [7:0] UM_CODE_ALL      = 8'h30;
    localparam logic [7:0] UM_PF_HIT        = 8'h40;
    localparam logic [7:0] UM_PF_MISS       = 8'h80;
    localparam logic [7:0] UM_PF_ALL        = 8'hc0;
    localparam logic [7:0] UM_LOCK_MISS     = 8'h01;
    localparam logic [7:0] UM_LOCK_HIT_E    = 8'h04;
    localparam logic [7:0] UM_LOCK_HIT_M    = 8'h08;
    localparam logic [7:0] UM_LOCK_ALL      = 8'h0f;
    localparam logic [7:0] UM_WB_HIT_E      = 8'h04;
    localparam logic [7:0] UM_WB_HIT_M      = 8'h08;
    localparam logic [7:0] UM_LLC_REFERENCE = 8'h4f;
    localparam logic [7:0] UM_LLC_MISS      = 8'h41;
    localparam logic [7:0] UM_CORE_CYCLES   = 8'h00;
    localparam logic [7:0] UM_REF_CYCLES    = 8'h01;

    // Counter slot that alone may count pending data misses.
    localparam logic [1:0] PENDING_SLOT = 2'h2;

    // Clock rates in MHz; the reference step is derived from both.
    localparam int REF_CLK_MHZ  = 100;
    localparam int CORE_CLK_MHZ = 40;

    // Register offsets and reset values.
    localparam logic [ADDR_W-1:0] REG_SELECT = 4'h0;
    localparam logic [ADDR_W-1:0] REG_COUNT  = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
    localparam logic [DATA_W-1:0] SELECT_RST = 32'h0;

    // Selection register layout, most significant field first.
    typedef struct packed {
        logic [THR_W-1:0]  threshold;
        logic [4:0]        spare;
        logic              edgeDetect;
        logic [1:0]        slot;
        logic [MASK_W-1:0] unitMask;
        logic [EVT_W-1:0]  eventNum;
    } sel_cfg_s;

    // One register access from the bus master.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
        logic              wrEn;
        logic              rdEn;
    } reg_req_s;

    // Per-cycle event counts from the pipeline and caches.
    typedef struct packed {
        logic [SRC_W-1:0] fpScalarSingle;
        logic [SRC_W-1:0] fpPackedSingle;
        logic [SRC_W-1:0] fpScalarDouble;
        logic [SRC_W-1:0] wideSingle;
        logic [SRC_W-1:0] wideDouble;
        logic [SRC_W-1:0] queueWrites;
        logic [SRC_W-1:0] l2DemandHit;
        logic [SRC_W-1:0] l2DemandOther;
        logic [SRC_W-1:0] l2RfoHit;
        logic [SRC_W-1:0] l2RfoMiss;
        logic [SRC_W-1:0] l2CodeHit;
        logic [SRC_W-1:0] l2CodeMiss;
        logic [SRC_W-1:0] l2PfHit;
        logic [SRC_W-1:0] l2PfMiss;
        logic [SRC_W-1:0] lockMiss;
        logic [SRC_W-1:0] lockHitS;
        logic [SRC_W-1:0] lockHitE;
        logic [SRC_W-1:0] lockHitM;
        logic [SRC_W-1:0] wbHitE;
        logic [SRC_W-1:0] wbHitM;
        logic [SRC_W-1:0] llcReference;
        logic [SRC_W-1:0] llcMiss;
        logic [SRC_W-1:0] pendingMisses;
        logic [SRC_W-1:0] storeWalks;
        logic             dividerBusy;
        logic             threadHalted;
    } event_src_s;

endpackage

// ### testbench/event_source_model.sv
// Purpose: Stands in for the pipeline and cache logic that feeds events.
// Assumes: One field changes per clock; all fields start at zero.
// Notes:   Index 0..23 picks a 4-bit count, 24 the divider, 25 the halt.
`timescale 1ns/1ps
module event_source_model (
    // Clock and reset.
    input  wire logic                       core_clk,
    input  wire logic                       sys_rst,
    // Field update request from the bench.
    input  wire logic                       setEn,
    input  wire logic [4:0]                 setIdx,
    input  wire logic [3:0]                 setVal,
    // Event counts towards the decoder.
    output core_event_pkg::event_src_s      events
);
    logic [23:0][3:0] nibReg;
    logic             busyReg;
    logic             haltReg;

    // Field 0 sits at the top of the carrier, so it is stored reversed.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nibReg  <= '0;
            busyReg <= 1'b0;
            haltReg <= 1'b0;
        end else if (setEn) begin
            if (setIdx < 5'd24) nibReg[5'd23 - setIdx] <= setVal;
            if (setIdx == 5'd24) busyReg <= setVal[0];
            if (setIdx == 5'd25) haltReg <= setVal[0];
        end
    end

    // Counts and levels are presented as one packed word.
    assign events = core_event_pkg::event_src_s'({nibReg, busyReg, haltReg});
endmodule

// ### testbench/core_event_select_decoder_test.sv
// Purpose: Checks event selection, masks, threshold and edge modes.
// Assumes: Each count field i holds i mod 7 plus 1 during the table.
// Notes:   Every run counts over exactly eight clock edges.
`timescale 1ns/1ps
module core_event_select_decoder_test;
    logic                       core_clk = 1'b0;
    logic                       sys_rst = 1'b1;
    core_event_pkg::reg_req_s   req = '0;
    core_event_pkg::event_src_s events;
    logic [31:0]                rdData;
    logic [31:0]                eventCount;
    logic                       setEn = 1'b0;
    logic [4:0]                 setIdx = 5'h0;
    logic [3:0]                 setVal = 4'h0;
    int                         mismatches = 0;
    int                         checksDone = 0;

    // Clock of 25 ns.
    always #12.5 core_clk = ~core_clk;

    core_event_select_decoder dut_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .busReq(req),
        .rdData(rdData), .events(events), .eventCount(eventCount));

    event_source_model src_u (
        .core_clk(core_clk), .sys_rst(sys_rst), .setEn(setEn),
        .setIdx(setIdx), .setVal(setVal), .events(events));

    // Builds a selection word from its fields.
    function automatic logic [31:0] mk(input logic [7:0] e,
        input logic [7:0] m, input logic [1:0] s, input logic ed,
        input logic [7:0] t);
        return {t, 5'h0, ed, s, m, e};
    endfunction

    // Sum of the per-cycle counts of the chosen fields, times eight edges.
    function automatic logic [31:0] fs(input logic [23:0] f);
        logic [31:0] acc;
        acc = 32'h0;
        for (int i = 0; i < 24; i++) if (f[i]) acc += 32'(i % 7 + 1);
        return acc * 32'h8;
    endfunction

    task automatic cmpCount(input logic [31:0] e);
        checksDone++;
        if (eventCount !== e) begin
            mismatches++;
            $display("FAIL %0t count got %h exp %h", $time, eventCount, e);
        end
    endtask

    task automatic cmpRead(input logic [31:0] e);
        checksDone++;
        if (rdData !== e) begin
            mismatches++;
            $display("FAIL %0t read got %h exp %h", $time, rdData, e);
        end
    endtask

    // One-cycle write strobe; returns at the edge that takes it.
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        req.addr <= a;
        req.wrData <= d;
        req.wrEn <= 1'b1;
        @(posedge core_clk);
        req.wrEn <= 1'b0;
    endtask

    // One-cycle read strobe; data is looked at in the following cycle.
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge core_clk);
        req.addr <= a;
        req.rdEn <= 1'b1;
        @(posedge core_clk);
        req.rdEn <= 1'b0;
        @(negedge core_clk);
        cmpRead(e);
    endtask

    task automatic put(input logic [4:0] i, input logic [3:0] v);
        @(posedge core_clk);
        setEn <= 1'b1;
        setIdx <= i;
        setVal <= v;
        @(posedge core_clk);
        setEn <= 1'b0;
    endtask

    // Clears the count, selects, counts eight edges, then deselects.
    task automatic run(input logic [31:0] sel, input logic [31:0] e);
        wr(core_event_pkg::REG_COUNT, 32'h0);
        wr(core_event_pkg::REG_SELECT, sel);
        repeat (6) @(posedge core_clk);
        wr(core_event_pkg::REG_SELECT, 32'h0);
        @(negedge core_clk);
        cmpCount(e);
        cmpRead(32'h0);
        rd(core_event_pkg::REG_COUNT, e);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Cuts a hang short far beyond the expected run length.
    initial begin
        repeat (6000) @(posedge core_clk);
        mismatches++;
        $display("FAIL %0t watchdog expired", $time);
        final_report();
    end

    // Main sequence.
    initial begin
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(core_event_pkg::REG_SELECT, 32'h0);
        rd(4'hc, 32'h0);
        for (int i = 0; i < 24; i++) put(5'(i), 4'(i % 7 + 1));
        run(mk(8'h10, 8'h20, 2'h0, 1'b0, 8'h0), fs(24'h000001));
        run(mk(8'h10, 8'h40, 2'h0, 1'b0, 8'h0), fs(24'h000002));
        run(mk(8'h10, 8'h80, 2'h0, 1'b0, 8'h0), fs(24'h000004));
        run(mk(8'h11, 8'h01, 2'h0, 1'b0, 8'h0), fs(24'h000008));
        run(mk(8'h11, 8'h02, 2'h0, 1'b0, 8'h0), fs(24'h000010));
        run(mk(8'h17, 8'h01, 2'h0, 1'b0, 8'h0), fs(24'h000020));
        run(mk(8'h24, 8'h01, 2'h0, 1'b0, 8'h0), fs(24'h000040));
        run(mk(8'h24, 8'h03, 2'h0, 1'b0, 8'h0), fs(24'h0000c0));
        run(mk(8'h24, 8'h04, 2'h0, 1'b0, 8'h0), fs(24'h000100));
        run(mk(8'h24, 8'h08, 2'h0, 1'b0, 8'h0), fs(24'h000200));
        run(mk(8'h24, 8'h0c, 2'h0, 1'b0, 8'h0), fs(24'h000300));
        run(mk(8'h24, 8'h10, 2'h0, 1'b0, 8'h0), fs(24'h000400));
        run(mk(8'h24, 8'h20, 2'h0, 1'b0, 8'h0), fs(24'h000800));
        run(mk(8'h24, 8'h30, 2'h0, 1'b0, 8'h0), fs(24'h000c00));
        run(mk(8'h24, 8'h40, 2'h0, 1'b0, 8'h0), fs(24'h001000));
        run(mk(8'h24, 8'h80, 2'h0, 1'b0, 8'h0), fs(24'h002000));
        run(mk(8'h24, 8'hc0, 2'h0, 1'b0, 8'h0), fs(24'h003000));
        run(mk(8'h27, 8'h01, 2'h0, 1'b0, 8'h0), fs(24'h004000));
        run(mk(8'h27, 8'h04, 2'h0, 1'b0, 8'h0), fs(24'h010000));
        run(mk(8'h27, 8'h08, 2'h0, 1'b0, 8'h0), fs(24'h020000));
        run(mk(8'h27, 8'h0f, 2'h0, 1'b0, 8'h0), fs(24'h03c000));
        run(mk(8'h28, 8'h04, 2'h0, 1'b0, 8'h0), fs(24'h040000));
        run(mk(8'h28, 8'h08, 2'h0, 1'b0, 8'h0), fs(24'h080000));
        run(mk(8'h2e, 8'h4f, 2'h0, 1'b0, 8'h0), fs(24'h100000));
        run(mk(8'h2e, 8'h41, 2'h0, 1'b0, 8'h0), fs(24'h200000));
        run(mk(8'h48, 8'h01, 2'h2, 1'b0, 8'h0), fs(24'h400000));
        run(mk(8'h48, 8'h01, 2'h1, 1'b0, 8'h0), 32'h0);
        run(mk(8'h49, 8'h01, 2'h0, 1'b0, 8'h0), fs(24'h800000));
        run(mk(8'h12, 8'h01, 2'h0, 1'b0, 8'h0), 32'h0);
        run(mk(8'h3c, 8'h00, 2'h0, 1'b0, 8'h0), 32'h8);
        run(mk(8'h3c, 8'h01, 2'h0, 1'b0, 8'h0), 32'h14);
        run(mk(8'h17, 8'h01, 2'h0, 1'b0, 8'h6), 32'h8);
        run(mk(8'h17, 8'h01, 2'h0, 1'b0, 8'h7), 32'h0);
        run(mk(8'h17, 8'h01, 2'h0, 1'b1, 8'h6), 32'h1);
        run(mk(8'h14, 8'h01, 2'h0, 1'b0, 8'h0), 32'h0);
        put(5'd24, 4'h1);
        run(mk(8'h14, 8'h01, 2'h0, 1'b0, 8'h0), 32'h8);
        run(mk(8'h14, 8'h01, 2'h0, 1'b1, 8'h1), 32'h1);
        put(5'd25, 4'h1);
        run(mk(8'h3c, 8'h00, 2'h0, 1'b0, 8'h0), 32'h0);
        run(mk(8'h3c, 8'h01, 2'h0, 1'b0, 8'h0), 32'h0);
        // Spare bits read back; the status word is not writable.
        wr(core_event_pkg::REG_SELECT, 32'hfffb_0117);
        rd(core_event_pkg::REG_SELECT, 32'hfffb_0117);
        wr(core_event_pkg::REG_STATUS, 32'h0);
        rd(core_event_pkg::REG_STATUS, 32'h1);
        wr(core_event_pkg::REG_SELECT, 32'h0);
        wr(core_event_pkg::REG_COUNT, 32'h1234_5678);
        rd(core_event_pkg::REG_COUNT, 32'h1234_5678);
        final_report();
    end
endmodule
